// ---- pwm_common_pkg.sv ----
// Purpose: Shared constants and types for the PWM common control block
// Assumes: APB byte addressing of word-aligned registers, 16-bit registers in the low half of each word
// Notes: Source ticks arrive as single-cycle enables in the pclk domain
package pwm_common_pkg;
    localparam int ADDR_WIDTH = 8;
    localparam int REG_WIDTH = 16;
    // Register byte offsets
    localparam logic [7:0] OFF_CLOCK_CONTROL = 8'h00;
    localparam logic [7:0] OFF_SCALE_STEP = 8'h04;
    localparam logic [7:0] OFF_SCALE_MIN_PERIOD = 8'h08;
    localparam logic [7:0] OFF_SHARED_PHASE = 8'h0c;
    localparam logic [7:0] OFF_SHARED_DUTY = 8'h10;
    localparam logic [7:0] OFF_UNLOCK_KEY = 8'h14;
    localparam logic [7:0] OFF_GEN4_IO_CONTROL = 8'h18;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h1c;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h20;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h24;
    // Field positions in pwm_clock_control
    localparam int BIT_HIRES_READY = 15;
    localparam int BIT_HIRES_ERROR = 14;
    localparam int BIT_LOCK = 8;
    localparam int LSB_DIVIDER_SELECT = 4;
    localparam int LSB_CLOCK_SELECT = 0;
    // Field positions in generator_io_control_high for generator 4
    localparam int BIT_HIGH_OUTPUT_ENABLE = 3;
    localparam int BIT_LOW_OUTPUT_ENABLE = 2;
    localparam int BIT_REMAP_ENABLE = 4;
    // Interrupt status bits
    localparam int IRQ_WIDTH = 4;
    localparam int IRQ_HIRES_ERROR = 0;
    localparam int IRQ_HIRES_READY = 1;
    localparam int IRQ_SCALED_PULSE = 2;
    localparam int IRQ_LOCK_REFUSED = 3;
    // Unlock keys and reset values
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [4:0] DIVIDE_BASE = 5'h02;

    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_FIRST_SEEN = 2'b01,
        KEY_ARMED = 2'b10
    } key_state_type;

    typedef enum logic [1:0] {
        SRC_SYSTEM_OSC = 2'b00,
        SRC_AUX_VCO_HALF = 2'b01,
        SRC_PRIMARY_PLL_POSTDIV = 2'b10,
        SRC_AUX_PLL_POSTDIV = 2'b11
    } clock_source_type;
endpackage : pwm_common_pkg

// ---- pwm_common_control.sv ----
// Purpose: Common PWM control: clock select/divide, frequency scaler, shared values, lock
// Assumes: source_tick bits are pclk-domain enables of the four master clock sources
// Notes: Pin and hires status inputs are asynchronous and pass a 3-flop filter
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps

// How it works
// - Generator 4 outputs appear on fixed and remapped pins together.
// - High and low output enables gate fixed and remapped pins together.
// - A remappable function on a fixed generator 4 pin beats the PWM.
// - Fixed generator 4 pin inputs are not routed while generator 4 is active.
// - Ready status bit reads 1 when hires circuitry is ready.
// - Hires fault sets sticky error; full resolution needs ready and no error.
// - Lock set blocks writes to protected registers and bits.
// - Lock bit clears only after a valid unlock sequence.
// - Key 0x55 then 0xAA, then one write, changes the lock bit.
// - Divider codes 00..11 divide the master clock by 2, 4, 8, 16.
// - Clock select codes pick system osc, aux VCO/2, primary PLL, aux PLL.
// - Step added per master clock; pulse when sum exceeds minimum period.
// - Holds a shared 16-bit phase offset for generators.
// - Holds a shared 16-bit duty cycle for generators.
module pwm_common_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pwm_common_pkg::ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [3:0] source_tick,
    input wire logic hires_ready_raw,
    input wire logic hires_fault_raw,
    input wire logic [1:0] gen4_pwm,
    input wire logic gen4_active,
    input wire logic [1:0] fixed_alt_select,
    input wire logic [1:0] fixed_alt_out,
    input wire logic [1:0] fixed_pin_in,
    output logic [1:0] fixed_pin_out,
    output logic [1:0] fixed_pin_oe,
    output logic [1:0] remap_pin_out,
    output logic [1:0] remap_pin_oe,
    output logic [1:0] fixed_pin_to_periph,
    output logic pwm_clock_tick,
    output logic scaled_clock_pulse,
    output logic full_resolution,
    output logic [pwm_common_pkg::REG_WIDTH-1:0] shared_phase_out,
    output logic [pwm_common_pkg::REG_WIDTH-1:0] shared_duty_out,
    output logic irq
);
    import pwm_common_pkg::*;

    // Input filter: bit0 ready, bit1 fault, bits 3:2 fixed pins
    logic [3:0] raw_in;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] filt;
    logic [3:0] next_filt;

    assign raw_in = {fixed_pin_in, hires_fault_raw, hires_ready_raw};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_filter
            // Change counts only when the second and third stages agree
            always_comb begin
                next_filt[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi] : filt[gi];
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    sync3[gi] <= 1'b0;
                    filt[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= raw_in[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    filt[gi] <= next_filt[gi];
                end
            end
        end
    endgenerate

    // APB decode
    logic wr;
    logic rd_setup;
    logic mapped;
    logic wr_ctl;
    logic wr_key;

    always_comb begin
        case (paddr)
            OFF_CLOCK_CONTROL, OFF_SCALE_STEP, OFF_SCALE_MIN_PERIOD, OFF_SHARED_PHASE,
            OFF_SHARED_DUTY, OFF_UNLOCK_KEY, OFF_GEN4_IO_CONTROL, OFF_IRQ_STATUS,
            OFF_IRQ_CLEAR, OFF_IRQ_ENABLE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign wr = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;
    assign wr_ctl = wr && (paddr == OFF_CLOCK_CONTROL);
    assign wr_key = wr && (paddr == OFF_UNLOCK_KEY);
    // Zero-wait slave: read data is captured in the setup cycle
    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;

    // Register state
    key_state_type key_state;
    key_state_type next_key_state;
    logic lock;
    logic next_lock;
    logic hires_error;
    logic next_hires_error;
    logic [1:0] divider_select;
    logic [1:0] next_divider_select;
    clock_source_type clock_select;
    clock_source_type next_clock_select;
    logic [15:0] scale_step;
    logic [15:0] next_scale_step;
    logic [15:0] min_period;
    logic [15:0] next_min_period;
    logic [15:0] next_shared_phase;
    logic [15:0] next_shared_duty;
    logic high_output_enable;
    logic next_high_output_enable;
    logic low_output_enable;
    logic next_low_output_enable;
    logic remap_enable;
    logic next_remap_enable;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] next_irq_status;
    logic [IRQ_WIDTH-1:0] irq_enable;
    logic [IRQ_WIDTH-1:0] next_irq_enable;
    logic [IRQ_WIDTH-1:0] events;
    logic [31:0] next_prdata;
    logic [15:0] ctl_word;
    logic lock_refused;

    always_comb begin
        ctl_word = RESET_WORD;
        ctl_word[BIT_HIRES_READY] = filt[0];
        ctl_word[BIT_HIRES_ERROR] = hires_error;
        ctl_word[BIT_LOCK] = lock;
        ctl_word[LSB_DIVIDER_SELECT +: 2] = divider_select;
        ctl_word[LSB_CLOCK_SELECT +: 2] = clock_select;
    end

    always_comb begin
        next_key_state = key_state;
        next_lock = lock;
        lock_refused = 1'b0;
        next_divider_select = divider_select;
        next_clock_select = clock_select;
        next_scale_step = scale_step;
        next_min_period = min_period;
        next_shared_phase = shared_phase_out;
        next_shared_duty = shared_duty_out;
        next_high_output_enable = high_output_enable;
        next_low_output_enable = low_output_enable;
        next_remap_enable = remap_enable;
        next_irq_enable = irq_enable;
        next_hires_error = hires_error;
        // Any write to a mapped register other than the expected key breaks the sequence
        if (wr) begin
            next_key_state = KEY_IDLE;
        end
        if (wr_key) begin
            case (key_state)
                KEY_IDLE: begin
                    if (pwdata[7:0] == KEY_FIRST) next_key_state = KEY_FIRST_SEEN;
                end
                KEY_FIRST_SEEN: begin
                    if (pwdata[7:0] == KEY_SECOND) next_key_state = KEY_ARMED;
                    else if (pwdata[7:0] == KEY_FIRST) next_key_state = KEY_FIRST_SEEN;
                end
                KEY_ARMED: begin
                    if (pwdata[7:0] == KEY_FIRST) next_key_state = KEY_FIRST_SEEN;
                end
                default: next_key_state = KEY_IDLE;
            endcase
        end
        if (wr_ctl) begin
            // Lock takes effect only on the write right after the key pair
            if (key_state == KEY_ARMED) begin
                next_lock = pwdata[BIT_LOCK];
            end else if (pwdata[BIT_LOCK] != lock) begin
                lock_refused = 1'b1;
            end
            // Uses the lock as it stood before this write
            if (!lock) begin
                next_divider_select = pwdata[LSB_DIVIDER_SELECT +: 2];
                next_clock_select = clock_source_type'(pwdata[LSB_CLOCK_SELECT +: 2]);
            end
            if (pwdata[BIT_HIRES_ERROR]) begin
                next_hires_error = 1'b0;
            end
        end
        // A fault present in the clearing cycle keeps the error set
        if (filt[1]) begin
            next_hires_error = 1'b1;
        end
        if (wr && !lock) begin
            case (paddr)
                OFF_SCALE_STEP: next_scale_step = pwdata[15:0];
                OFF_SCALE_MIN_PERIOD: next_min_period = pwdata[15:0];
                OFF_GEN4_IO_CONTROL: begin
                    next_high_output_enable = pwdata[BIT_HIGH_OUTPUT_ENABLE];
                    next_low_output_enable = pwdata[BIT_LOW_OUTPUT_ENABLE];
                    next_remap_enable = pwdata[BIT_REMAP_ENABLE];
                end
                default: ;
            endcase
        end
        if (wr) begin
            case (paddr)
                OFF_SHARED_PHASE: next_shared_phase = pwdata[15:0];
                OFF_SHARED_DUTY: next_shared_duty = pwdata[15:0];
                OFF_IRQ_ENABLE: next_irq_enable = pwdata[IRQ_WIDTH-1:0];
                default: ;
            endcase
        end
        events = '0;
        events[IRQ_HIRES_ERROR] = filt[1] && !hires_error;
        events[IRQ_HIRES_READY] = next_filt[0] && !filt[0];
        events[IRQ_SCALED_PULSE] = scaled_clock_pulse;
        events[IRQ_LOCK_REFUSED] = lock_refused;
        // Set wins over a clear in the same cycle
        next_irq_status = irq_status;
        if (wr && (paddr == OFF_IRQ_CLEAR)) begin
            next_irq_status = irq_status & ~pwdata[IRQ_WIDTH-1:0];
        end
        next_irq_status = next_irq_status | events;
        next_prdata = prdata;
        if (rd_setup) begin
            case (paddr)
                OFF_CLOCK_CONTROL: next_prdata = {16'h0000, ctl_word};
                OFF_SCALE_STEP: next_prdata = {16'h0000, scale_step};
                OFF_SCALE_MIN_PERIOD: next_prdata = {16'h0000, min_period};
                OFF_SHARED_PHASE: next_prdata = {16'h0000, shared_phase_out};
                OFF_SHARED_DUTY: next_prdata = {16'h0000, shared_duty_out};
                OFF_GEN4_IO_CONTROL: begin
                    next_prdata = '0;
                    next_prdata[BIT_HIGH_OUTPUT_ENABLE] = high_output_enable;
                    next_prdata[BIT_LOW_OUTPUT_ENABLE] = low_output_enable;
                    next_prdata[BIT_REMAP_ENABLE] = remap_enable;
                end
                OFF_IRQ_STATUS: next_prdata = {28'h000_0000, irq_status};
                OFF_IRQ_ENABLE: next_prdata = {28'h000_0000, irq_enable};
                default: next_prdata = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_state <= KEY_IDLE;
            lock <= 1'b0;
            hires_error <= 1'b0;
            divider_select <= 2'b00;
            clock_select <= SRC_SYSTEM_OSC;
            scale_step <= RESET_WORD;
            min_period <= RESET_WORD;
            shared_phase_out <= RESET_WORD;
            shared_duty_out <= RESET_WORD;
            high_output_enable <= 1'b0;
            low_output_enable <= 1'b0;
            remap_enable <= 1'b0;
            irq_status <= '0;
            irq_enable <= '0;
            prdata <= '0;
        end else begin
            key_state <= next_key_state;
            lock <= next_lock;
            hires_error <= next_hires_error;
            divider_select <= next_divider_select;
            clock_select <= next_clock_select;
            scale_step <= next_scale_step;
            min_period <= next_min_period;
            shared_phase_out <= next_shared_phase;
            shared_duty_out <= next_shared_duty;
            high_output_enable <= next_high_output_enable;
            low_output_enable <= next_low_output_enable;
            remap_enable <= next_remap_enable;
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
            prdata <= next_prdata;
        end
    end

    assign irq = |(irq_status & irq_enable);
    assign full_resolution = filt[0] && !hires_error;

    // Master clock, divider and frequency scaler
    logic master_tick;
    logic [3:0] div_count;
    logic [3:0] next_div_count;
    logic [3:0] div_last;
    logic next_pwm_clock_tick;
    logic [15:0] accum;
    logic [15:0] next_accum;
    logic [16:0] accum_sum;
    logic [16:0] accum_rem;
    logic next_scaled_clock_pulse;

    assign master_tick = source_tick[clock_select];
    assign div_last = 4'((DIVIDE_BASE << divider_select) - 5'h01);

    always_comb begin
        next_div_count = div_count;
        next_pwm_clock_tick = 1'b0;
        if (master_tick) begin
            if (div_count >= div_last) begin
                next_div_count = 4'h0;
                next_pwm_clock_tick = 1'b1;
            end else begin
                next_div_count = div_count + 4'h1;
            end
        end
        accum_sum = {1'b0, accum} + {1'b0, scale_step};
        accum_rem = accum_sum - {1'b0, min_period};
        next_accum = accum;
        next_scaled_clock_pulse = 1'b0;
        if (master_tick) begin
            if (accum_sum > {1'b0, min_period}) begin
                next_scaled_clock_pulse = 1'b1;
                // Clamp keeps the remainder bounded when step exceeds min period
                next_accum = (accum_rem > {1'b0, min_period}) ? min_period : accum_rem[15:0];
            end else begin
                next_accum = accum_sum[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_count <= 4'h0;
            pwm_clock_tick <= 1'b0;
            accum <= RESET_WORD;
            scaled_clock_pulse <= 1'b0;
        end else begin
            div_count <= next_div_count;
            pwm_clock_tick <= next_pwm_clock_tick;
            accum <= next_accum;
            scaled_clock_pulse <= next_scaled_clock_pulse;
        end
    end

    // Generator 4 pin routing; index 1 is the high output, 0 the low
    logic [1:0] pin_enable;
    logic [1:0] next_fixed_out;
    logic [1:0] next_fixed_oe;
    logic [1:0] next_remap_out;
    logic [1:0] next_remap_oe;
    logic [1:0] next_to_periph;

    assign pin_enable = {high_output_enable, low_output_enable};

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (fixed_alt_select[i]) begin
                next_fixed_out[i] = fixed_alt_out[i];
                next_fixed_oe[i] = 1'b1;
            end else begin
                next_fixed_out[i] = gen4_pwm[i];
                next_fixed_oe[i] = pin_enable[i];
            end
            next_remap_out[i] = gen4_pwm[i];
            next_remap_oe[i] = remap_enable && pin_enable[i];
            next_to_periph[i] = gen4_active ? 1'b0 : filt[2 + i];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fixed_pin_out <= 2'b00;
            fixed_pin_oe <= 2'b00;
            remap_pin_out <= 2'b00;
            remap_pin_oe <= 2'b00;
            fixed_pin_to_periph <= 2'b00;
        end else begin
            fixed_pin_out <= next_fixed_out;
            fixed_pin_oe <= next_fixed_oe;
            remap_pin_out <= next_remap_out;
            remap_pin_oe <= next_remap_oe;
            fixed_pin_to_periph <= next_to_periph;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_both_pins_driven: assert property (
        remap_enable && high_output_enable && !fixed_alt_select[1]
        |=> remap_pin_oe[1] && fixed_pin_oe[1] && (fixed_pin_out[1] == remap_pin_out[1]))
        else $error("fixed and remapped high pins differ");
    a_remap_needs_enable: assert property (
        remap_pin_oe[0] |-> $past(low_output_enable) && $past(remap_enable))
        else $error("remapped low pin enabled without its enable");
    a_alt_has_priority: assert property (
        fixed_alt_select[0] |=> fixed_pin_oe[0] && fixed_pin_out[0] == $past(fixed_alt_out[0]))
        else $error("alternate function lost the fixed pin");
    a_input_blocked: assert property (
        gen4_active |=> fixed_pin_to_periph == 2'b00)
        else $error("fixed pin input routed while generator 4 active");
    a_error_sticky: assert property (
        hires_error && !(wr_ctl && pwdata[BIT_HIRES_ERROR]) |=> hires_error)
        else $error("hires error dropped without a clear");
    a_lock_blocks_config: assert property (
        lock && wr_ctl |=> $stable(divider_select) && $stable(clock_select))
        else $error("locked clock control changed");
    a_lock_needs_keys: assert property (
        $changed(lock) |-> $past(key_state) == KEY_ARMED && $past(wr_ctl))
        else $error("lock changed without unlock sequence");
    a_key_sequence: assert property (
        (wr_key && pwdata[7:0] == KEY_FIRST) ##[2:3] (wr_key && pwdata[7:0] == KEY_SECOND)
        |=> key_state == KEY_ARMED)
        else $error("key pair did not arm the lock");
    a_divider_ratio: assert property (
        master_tick && div_count == ((4'h2 << divider_select) - 4'h1) |=> pwm_clock_tick)
        else $error("divider missed its terminal count");
    a_scaled_pulse: assert property (
        master_tick && ({1'b0, accum} + {1'b0, scale_step}) > {1'b0, min_period}
        |=> scaled_clock_pulse)
        else $error("scaled clock pulse missing");
    a_pulse_single: assert property (
        scaled_clock_pulse && !master_tick |=> !scaled_clock_pulse)
        else $error("scaled pulse longer than one master clock");
    a_shared_phase: assert property (
        wr && paddr == OFF_SHARED_PHASE |=> shared_phase_out == $past(pwdata[15:0]))
        else $error("shared phase not stored");
endmodule : pwm_common_control

// ---- clock_source_model.sv ----
// Purpose: Model of the four master clock sources feeding the block
// Assumes: Source k ticks once every k+1 pclk cycles
// Notes: Distinct rates let the bench tell the selected source apart
`timescale 1ns/1ps
module clock_source_model (
    input wire logic pclk,
    input wire logic presetn,
    output logic [3:0] source_tick
);
    logic [1:0] cnt [4];
    always_ff @(posedge pclk or negedge presetn) begin
        for (int k = 0; k < 4; k++) begin
            if (!presetn) begin
                cnt[k] <= 2'h0;
            end else begin
                cnt[k] <= (cnt[k] == 2'(k)) ? 2'h0 : cnt[k] + 2'h1;
            end
        end
    end
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            source_tick[k] = presetn && (cnt[k] == 2'h0);
        end
    end
endmodule : clock_source_model

// ---- pwm_common_clock_and_master_values_tb.sv ----
// Purpose: Self-checking bench for the PWM common control block
// Assumes: Zero-wait APB slave, sources from clock_source_model
// Notes: Pulse counts allow one pulse of slack for start phase
`timescale 1ns/1ps
module pwm_common_clock_and_master_values_tb;
    import pwm_common_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] source_tick;
    logic hr_rdy, hr_flt, g4_act, clk_tick, sc_pulse, full_res;
    logic [1:0] g4_pwm, alt_sel, alt_out, pin_in, f_out, f_oe, r_out, r_oe, to_per;
    logic [15:0] ph_out, dc_out;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    pwm_common_control i_pwm_common_control (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .source_tick(source_tick),
        .hires_ready_raw(hr_rdy), .hires_fault_raw(hr_flt), .gen4_pwm(g4_pwm),
        .gen4_active(g4_act), .fixed_alt_select(alt_sel), .fixed_alt_out(alt_out),
        .fixed_pin_in(pin_in), .fixed_pin_out(f_out), .fixed_pin_oe(f_oe),
        .remap_pin_out(r_out), .remap_pin_oe(r_oe), .fixed_pin_to_periph(to_per),
        .pwm_clock_tick(clk_tick), .scaled_clock_pulse(sc_pulse),
        .full_resolution(full_res), .shared_phase_out(ph_out), .shared_duty_out(dc_out),
        .irq(irq));
    clock_source_model i_clock_source_model (.pclk(pclk), .presetn(presetn),
        .source_tick(source_tick));
    task wrap_up;
        if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int g;
        g = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            g++;
        end while (pready !== 1'b1 && g < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, rd, exp);
    endtask : rdchk
    task count(input logic sel, input int exp, input string name);
        int n;
        int d;
        n = 0;
        repeat (20) @(posedge pclk);
        repeat (240) begin
            @(posedge pclk);
            n += sel ? int'(sc_pulse) : int'(clk_tick);
        end
        d = n - exp;
        chk(name, 32'(d >= -1 && d <= 1), 32'h0000_0001);
    endtask : count
    task t_basic;
        for (int a = 0; a <= 16; a += 4) rdchk("reset_value", 8'(a), 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped_err", 32'(er), 32'h0000_0001);
        apb(1'b1, OFF_SHARED_PHASE, 32'h0000_1234);
        apb(1'b1, OFF_SHARED_DUTY, 32'h0000_0020);
        rdchk("phase", OFF_SHARED_PHASE, 32'h0000_1234);
        chk("phase_out", 32'(ph_out), 32'h0000_1234);
        chk("duty_out", 32'(dc_out), 32'h0000_0020);
    endtask : t_basic
    task t_clock;
        // Generator stays idle while the source changes
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, OFF_CLOCK_CONTROL, 32'(s));
            count(1'b0, 120 / (s + 1), "source_rate");
        end
        for (int v = 0; v < 4; v++) begin
            apb(1'b1, OFF_CLOCK_CONTROL, 32'(v << 4));
            count(1'b0, 240 >> (v + 1), "divide_rate");
        end
    endtask : t_clock
    task t_scaler;
        apb(1'b1, OFF_CLOCK_CONTROL, 32'h0000_0000);
        apb(1'b1, OFF_SCALE_STEP, 32'h0000_0003);
        apb(1'b1, OFF_SCALE_MIN_PERIOD, 32'h0000_0009);
        apb(1'b1, OFF_IRQ_ENABLE, 32'h0000_0004);
        count(1'b1, 80, "scaled_rate");
        chk("irq_set", 32'(irq), 32'h0000_0001);
        apb(1'b1, OFF_IRQ_ENABLE, 32'h0000_0000);
        @(posedge pclk);
        chk("irq_mask", 32'(irq), 32'h0000_0000);
        apb(1'b1, OFF_CLOCK_CONTROL, 32'h0000_0001);
        count(1'b1, 40, "scaled_slow");
        apb(1'b1, OFF_SCALE_STEP, 32'h0000_0000);
        repeat (4) @(posedge pclk);
        apb(1'b1, OFF_IRQ_CLEAR, 32'h0000_0004);
        rdchk("irq_clear", OFF_IRQ_STATUS, 32'h0000_0000);
    endtask : t_scaler
    task keys;
        apb(1'b1, OFF_UNLOCK_KEY, 32'(KEY_FIRST));
        apb(1'b1, OFF_UNLOCK_KEY, 32'(KEY_SECOND));
    endtask : keys
    task t_lock;
        keys();
        apb(1'b1, OFF_CLOCK_CONTROL, 32'h0000_0100);
        rdchk("lock_set", OFF_CLOCK_CONTROL, 32'h0000_0100);
        apb(1'b1, OFF_SCALE_STEP, 32'h0000_0007);
        rdchk("locked_step", OFF_SCALE_STEP, 32'h0000_0000);
        apb(1'b1, OFF_CLOCK_CONTROL, 32'h0000_0000);
        rdchk("no_key_clear", OFF_CLOCK_CONTROL, 32'h0000_0100);
        rdchk("refused_irq", OFF_IRQ_STATUS, 32'h0000_0008);
        apb(1'b1, OFF_UNLOCK_KEY, 32'(KEY_FIRST));
        apb(1'b1, OFF_SHARED_PHASE, 32'h0000_0006);
        apb(1'b1, OFF_UNLOCK_KEY, 32'(KEY_SECOND));
        apb(1'b1, OFF_CLOCK_CONTROL, 32'h0000_0000);
        rdchk("broken_keys", OFF_CLOCK_CONTROL, 32'h0000_0100);
        keys();
        apb(1'b1, OFF_CLOCK_CONTROL, 32'h0000_0000);
        rdchk("lock_clear", OFF_CLOCK_CONTROL, 32'h0000_0000);
        apb(1'b1, OFF_SCALE_STEP, 32'h0000_0007);
        rdchk("open_step", OFF_SCALE_STEP, 32'h0000_0007);
        apb(1'b1, OFF_IRQ_CLEAR, 32'h0000_0008);
    endtask : t_lock
    task t_hires;
        hr_rdy <= 1'b1;
        repeat (8) @(posedge pclk);
        rdchk("ready_bit", OFF_CLOCK_CONTROL, 32'h0000_8000);
        chk("full_res", 32'(full_res), 32'h0000_0001);
        hr_flt <= 1'b1;
        repeat (8) @(posedge pclk);
        rdchk("error_bit", OFF_CLOCK_CONTROL, 32'h0000_c000);
        chk("reduced_res", 32'(full_res), 32'h0000_0000);
        hr_flt <= 1'b0;
        repeat (8) @(posedge pclk);
        rdchk("error_sticky", OFF_CLOCK_CONTROL, 32'h0000_c000);
        apb(1'b1, OFF_CLOCK_CONTROL, 32'h0000_4000);
        rdchk("error_clear", OFF_CLOCK_CONTROL, 32'h0000_8000);
        rdchk("hires_events", OFF_IRQ_STATUS, 32'h0000_0007);
    endtask : t_hires
    task t_pins;
        g4_pwm <= 2'b10;
        apb(1'b1, OFF_GEN4_IO_CONTROL, 32'h0000_001c);
        repeat (6) @(posedge pclk);
        chk("fixed_out", 32'(f_out), 32'h0000_0002);
        chk("remap_out", 32'(r_out), 32'h0000_0002);
        chk("oe_both", 32'({f_oe, r_oe}), 32'h0000_000f);
        apb(1'b1, OFF_GEN4_IO_CONTROL, 32'h0000_0018);
        repeat (6) @(posedge pclk);
        chk("oe_high", 32'({f_oe, r_oe}), 32'h0000_000a);
        alt_sel <= 2'b01;
        alt_out <= 2'b01;
        apb(1'b1, OFF_GEN4_IO_CONTROL, 32'h0000_001c);
        repeat (6) @(posedge pclk);
        chk("alt_wins", 32'({f_out, r_out}), 32'h0000_000e);
        pin_in <= 2'b11;
        repeat (8) @(posedge pclk);
        chk("pin_in", 32'(to_per), 32'h0000_0003);
        g4_act <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("pin_block", 32'(to_per), 32'h0000_0000);
    endtask : t_pins
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        forever begin
            @(posedge pclk);
            cycles++;
            if (cycles == 20000) begin
                n_mismatch++;
                wrap_up();
            end
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, hr_rdy, hr_flt, g4_act} = 7'h00;
        {paddr, pwdata, g4_pwm, alt_sel, alt_out, pin_in} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_basic();
        t_clock();
        t_scaler();
        t_lock();
        t_hires();
        t_pins();
        wrap_up();
    end
endmodule : pwm_common_clock_and_master_values_tb
